// File: design/acq_sequencer.sv
// Acquisition sequencer: start sources, point list, sample FIFO, tagging and interrupt
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// Operation
// R1: Conversion starts from software command, on-board timer, or external trigger.
// R2: Host may poll end-of-conversion, poll half-full, or take half-full interrupt.
// R3: Sample FIFO and point-list buffer are each 4k entries deep.
// R4: Timer-started acquisition runs unattended until the sample FIFO needs draining.
// R5: Register at offset 3 holds 4-bit channel select and 3-bit gain.
// R6: Top four bits of each result carry the current channel select value; with a point list loaded the code uses the entry's top nibble.
// R7: Without a submultiplexer, host may use channel select as sample ID tag.
// R8: Software selects eight differential or sixteen single-ended input channels.
// R9: Channel select addresses up to 16 expansion cards, 256 inputs total.
// R10: Sequencing supports over 100,000 conversions per second.
// R11: Cascaded timer clocked from 1 MHz generates periodic conversion starts.
// R12: Card interrupt is software enabled and raised from FIFO status conditions.
// R13: Half-full flag set at half capacity, cleared once drained below it.
module acq_sequencer
	import acq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Converter front end
	input  wire logic        ext_trig_i,
	input  wire logic [11:0] adc_data_i,
	output logic             convert_o,
	output logic      [3:0]  mux_chan_o,
	output logic             diff_mode_o,
	output logic      [3:0]  submux_channel_select_o,
	output logic      [2:0]  gain_select_o,
	// Interrupt
	output logic             irq_o
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0]        control_r;
	logic [7:0]         chgain_r;
	logic [ST_W-1:0]    status_r;
	logic [ST_W-1:0]    mask_r;
	logic [31:0]        timer_div_r;
	logic [31:0]        timer_cnt_r;
	logic [7:0]         tick_cnt_r;
	logic               ext_d_r;
	logic [PL_AW-1:0]   pl_wr_r;
	logic [PL_AW-1:0]   pl_rd_r;
	logic [PL_AW:0]     pl_count_r;
	logic [PL_W-1:0]    plist [0:4095];
	logic [15:0]        fifo [0:FIFO_DEPTH-1];
	logic [FIFO_AW-1:0] f_wr_r;
	logic [FIFO_AW-1:0] f_rd_r;
	logic [FIFO_AW:0]   f_level_r;
	logic [15:0]        f_head_r;
	logic [15:0]        conv_cnt_r;
	logic [PL_W-1:0]    cur_entry_r;
	acq_state_t         state_r;
	logic               half_prev_r;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire req      = cyc_i & stb_i & ~ack_o;
	wire wr       = req & we_i & sel_i[0];
	wire rd       = req & ~we_i;
	wire hit_ctl  = adr_i == ADR_CONTROL;
	wire hit_cg   = adr_i == ADR_CHGAIN;
	wire hit_st   = adr_i == ADR_STATUS;
	wire hit_mk   = adr_i == ADR_MASK;
	wire hit_dat  = adr_i == ADR_DATA;
	wire hit_tmr  = adr_i == ADR_TIMER;
	wire hit_pl   = adr_i == ADR_PLIST;
	wire hit_plc  = adr_i == ADR_PLCOUNT;
	wire hit_lvl  = adr_i == ADR_LEVEL;
	wire [1:0] src = control_r[CTL_SRC_HI:CTL_SRC_LO];
	wire run      = control_r[CTL_RUN];
	wire f_empty  = f_level_r == '0;
	wire f_full   = f_level_r == (FIFO_AW+1)'(FIFO_DEPTH);
	wire half     = f_level_r >= (FIFO_AW+1)'(HALF_LEVEL); // R13
	wire f_pop    = rd & hit_dat & ~f_empty;
	wire pl_push  = wr & hit_pl & (pl_count_r != (PL_AW+1)'(4096)); // R3
	wire pl_clr   = wr & hit_ctl & dat_i[CTL_PL_RESET];
	wire f_clr    = wr & hit_ctl & dat_i[CTL_FIFO_CLR];
	wire tick     = tick_cnt_r == 8'(TICK_CYC - 1); // R11
	wire tmr_fire = tick & run & (timer_cnt_r == 32'h0000_0000) & (timer_div_r != 32'h0000_0000);
	wire ext_edge = ext_trig_i & ~ext_d_r;
	wire sw_start = wr & hit_ctl & dat_i[CTL_SW_START];
	// Start source select; timer keeps firing while run is set, even with the FIFO full
	wire start    = (src == SRC_SOFT  & sw_start) |
	                (src == SRC_TIMER & tmr_fire) |
	                (src == SRC_EXT   & run & ext_edge); // R1 R4
	wire pl_any   = pl_count_r != '0;
	wire [PL_W-1:0] entry = pl_any ? plist[pl_rd_r] : {chgain_r[3:0], 4'h0};
	wire conv_done = (state_r == SQ_CONV) & (conv_cnt_r == 16'(CONV_CYC - 1));
	wire f_push   = (state_r == SQ_STORE) & ~f_full;
	wire overrun  = (state_r == SQ_STORE) & f_full;
	// Result tagged with the current entry's top nibble (submux select only when the point list is empty)
	wire [15:0] sample = {cur_entry_r[7:4], adc_data_i}; // R6 R9
	wire [ST_W-1:0] ev = {overrun, half & ~half_prev_r, f_push};
	wire [15:0] level_ext = 16'(f_level_r);
	wire [31:0] rd_mux =
		hit_ctl ? {24'h0, control_r[7:6] & 2'b00, control_r[5:0] & 6'h2F} :
		hit_cg  ? {24'h0, chgain_r} :
		hit_st  ? {27'h0, f_empty, half, status_r} :
		hit_mk  ? {29'h0, mask_r} :
		hit_dat ? {16'h0, f_head_r} :
		hit_tmr ? timer_div_r :
		hit_plc ? {19'h0, pl_count_r} :
		hit_lvl ? {16'h0, level_ext} : 32'h0000_0000;

	// ----------------------------------------
	// Wishbone answer, one cycle after request
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req;
			dat_o <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_r   <= CONTROL_RST;
			chgain_r    <= CHGAIN_RST;
			mask_r      <= '0;
			timer_div_r <= 32'h0000_0000;
		end else if (wr) begin
			if (hit_ctl)
				control_r <= dat_i & 32'h0000_002F; // R2 R8 R12
			if (hit_cg)
				chgain_r <= dat_i[7:0] & 8'h7F; // R5
			if (hit_mk)
				mask_r <= dat_i[ST_W-1:0];
			if (hit_tmr)
				timer_div_r <= dat_i;
		end
	end

	// ----------------------------------------
	// Timer: 1 MHz tick into a 32-bit divider
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_r  <= 8'h00;
			timer_cnt_r <= 32'h0000_0000;
			ext_d_r     <= 1'b0;
		end else begin
			ext_d_r    <= ext_trig_i;
			tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
			// Zero divider parks the count, so a later divider fires on the next tick
			if (!run || timer_div_r == 32'h0000_0000)
				timer_cnt_r <= 32'h0000_0000;
			else if (tick)
				timer_cnt_r <= (timer_cnt_r == 32'h0000_0000) ? timer_div_r - 32'h0000_0001
				                                              : timer_cnt_r - 32'h0000_0001; // R11
		end
	end

	// ----------------------------------------
	// Point list
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (pl_push)
			plist[pl_wr_r] <= dat_i[PL_W-1:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || pl_clr) begin
			pl_wr_r    <= '0;
			pl_rd_r    <= '0;
			pl_count_r <= '0;
		end else begin
			if (pl_push) begin
				pl_wr_r    <= pl_wr_r + PL_AW'(1);
				pl_count_r <= pl_count_r + (PL_AW+1)'(1);
			end
			// Wrap back to the first entry after the last
			if (start && state_r == SQ_IDLE && pl_any)
				pl_rd_r <= (pl_rd_r + PL_AW'(1) == pl_wr_r) ? '0 : pl_rd_r + PL_AW'(1);
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r     <= SQ_IDLE;
			conv_cnt_r  <= 16'h0000;
			cur_entry_r <= 8'h00;
		end else begin
			case (state_r)
				SQ_IDLE: begin
					conv_cnt_r <= 16'h0000;
					if (start) begin
						cur_entry_r <= entry;
						state_r     <= SQ_CONV;
					end
				end
				SQ_CONV: begin
					conv_cnt_r <= conv_cnt_r + 16'h0001;
					if (conv_done)
						state_r <= SQ_STORE; // R10
				end
				SQ_STORE:
					state_r <= SQ_IDLE;
				default:
					state_r <= SQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Sample FIFO
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (f_push)
			fifo[f_wr_r] <= sample;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || f_clr) begin
			f_wr_r    <= '0;
			f_rd_r    <= '0;
			f_level_r <= '0;
			f_head_r  <= 16'h0000;
		end else begin
			if (f_push)
				f_wr_r <= f_wr_r + FIFO_AW'(1);
			if (f_pop)
				f_rd_r <= f_rd_r + FIFO_AW'(1);
			f_level_r <= f_level_r + (FIFO_AW+1)'(f_push) - (FIFO_AW+1)'(f_pop); // R3
			f_head_r  <= fifo[f_pop ? f_rd_r + FIFO_AW'(1) : f_rd_r];
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r    <= '0;
			half_prev_r <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			half_prev_r <= half;
			// New event wins over the read that clears
			status_r <= ((rd && hit_st) ? '0 : status_r) | ev; // R2
			irq_o    <= control_r[CTL_IRQ_EN] & |(status_r & mask_r); // R12
		end
	end

	// ----------------------------------------
	// Front-end outputs
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			convert_o               <= 1'b0;
			mux_chan_o              <= 4'h0;
			diff_mode_o             <= 1'b0;
			submux_channel_select_o <= 4'h0;
			gain_select_o           <= 3'h0;
		end else begin
			convert_o               <= state_r == SQ_CONV && conv_cnt_r == 16'h0000;
			diff_mode_o             <= control_r[CTL_DIFF]; // R8
			mux_chan_o              <= control_r[CTL_DIFF] ? {1'b0, cur_entry_r[2:0]} : cur_entry_r[3:0];
			submux_channel_select_o <= chgain_r[GAIN_LO-1:SEL_LO]; // R5 R9
			gain_select_o           <= chgain_r[GAIN_LO+2:GAIN_LO];
		end
	end

endmodule : acq_sequencer

// File: design/acq_pkg.sv
// Package with register map, field layout and timing constants for the acquisition sequencer
package acq_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADR_CONTROL  = 8'h00;
	localparam logic [7:0] ADR_CHGAIN   = 8'h0C;
	localparam logic [7:0] ADR_STATUS   = 8'h10;
	localparam logic [7:0] ADR_MASK     = 8'h14;
	localparam logic [7:0] ADR_DATA     = 8'h18;
	localparam logic [7:0] ADR_TIMER    = 8'h1C;
	localparam logic [7:0] ADR_PLIST    = 8'h20;
	localparam logic [7:0] ADR_PLCOUNT  = 8'h24;
	localparam logic [7:0] ADR_LEVEL    = 8'h28;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int CTL_SRC_LO    = 0;
	localparam int CTL_SRC_HI    = 1;
	localparam int CTL_DIFF      = 2;
	localparam int CTL_IRQ_EN    = 3;
	localparam int CTL_SW_START  = 4;
	localparam int CTL_RUN       = 5;
	localparam int CTL_PL_RESET  = 6;
	localparam int CTL_FIFO_CLR  = 7;
	localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
	localparam logic [7:0]  CHGAIN_RST  = 8'h00;

	// Start sources
	localparam logic [1:0] SRC_SOFT  = 2'h0;
	localparam logic [1:0] SRC_TIMER = 2'h1;
	localparam logic [1:0] SRC_EXT   = 2'h2;

	// Channel/gain register fields
	localparam int SEL_LO  = 0;
	localparam int GAIN_LO = 4;

	// ----------------------------------------
	// Status / mask bits
	// ----------------------------------------
	localparam int ST_EOC  = 0;
	localparam int ST_HALF = 1;
	localparam int ST_OVR  = 2;
	localparam int ST_W    = 3;
	localparam int LIVE_HALF  = 3;
	localparam int LIVE_EMPTY = 4;

	// ----------------------------------------
	// Buffers
	// ----------------------------------------
	localparam int FIFO_AW    = 12;
	localparam int FIFO_DEPTH = 4096;
	localparam int HALF_LEVEL = FIFO_DEPTH / 2;
	localparam int PL_AW      = 12;
	localparam int PL_W       = 8;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ      = 250_000_000;
	localparam int TICK_HZ     = 1_000_000;
	localparam int TICK_CYC    = CLK_HZ / TICK_HZ;
	localparam int CONV_NS     = 8000;
	localparam int CONV_CYC    = (CONV_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_CONV = 2'b01,
		SQ_STORE = 2'b11
	} acq_state_t;

endpackage : acq_pkg

// File: dv/acq_adc_model.sv
// Converter model: hands back a new result after every start pulse
`timescale 1ns/1ns
module acq_adc_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Converter handshake
	input  wire logic        convert_i,
	output logic      [11:0] data_o
);
	// Step of 12'h111 makes every result in a run distinct
	always_ff @(posedge clk_i) begin
		if (rst_i) data_o <= 12'h000;
		else if (convert_i) data_o <= data_o + 12'h111;
	end
endmodule : acq_adc_model

// File: dv/acq_properties.sv
// Port-level assertions for the acquisition sequencer
`timescale 1ns/1ns
module acq_checker
	import acq_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        convert_o,
	input wire logic        diff_mode_o,
	input wire logic [3:0]  submux_channel_select_o,
	input wire logic [2:0]  gain_select_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	property p_dat_zero; !ack_o |-> dat_o == 32'h0000_0000; endproperty
	property p_unmapped; ack_o && !we_i && adr_i > ADR_LEVEL |-> dat_o == 32'h0000_0000; endproperty
	property p_conv_gap; convert_o |=> !convert_o [*8]; endproperty
	property p_chgain;
		ack_o && we_i && sel_i[0] && adr_i == ADR_CHGAIN
			|=> {gain_select_o, submux_channel_select_o} == $past(dat_i[6:0]);
	endproperty
	property p_diff;
		ack_o && we_i && sel_i[0] && adr_i == ADR_CONTROL |=> diff_mode_o == $past(dat_i[CTL_DIFF]);
	endproperty
	property p_rst; $fell(rst_i) |-> !ack_o && !irq_o && !convert_o && dat_o == 32'h0000_0000; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
	a_ack_resp: assert property (p_ack_resp) else $error("request not acked");
	a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_conv_gap: assert property (p_conv_gap) else $error("conversion restarted early");
	a_chgain: assert property (p_chgain) else $error("channel gain outputs wrong");
	a_diff: assert property (p_diff) else $error("input mode output wrong");
	a_rst: assert property (p_rst) else $error("output active after reset");
	c_irq: cover property (irq_o);
	c_conv: cover property (convert_o);
	c_data: cover property (ack_o && !we_i && adr_i == ADR_DATA);
endmodule : acq_checker
bind acq_sequencer acq_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
	.ack_o, .convert_o, .diff_mode_o, .submux_channel_select_o, .gain_select_o, .irq_o);

// File: dv/testbench.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ns
module testbench;
	import acq_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ext_trig_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
	logic ack_o, convert_o, diff_mode_o, irq_o;
	logic [11:0] adc_data_i;
	logic [3:0] mux_chan_o, submux_channel_select_o;
	logic [2:0] gain_select_o;
	int errors = 0, checks_done = 0;
	always #2 clk_i = ~clk_i;
	acq_sequencer u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.ext_trig_i, .adc_data_i, .convert_o, .mux_chan_o, .diff_mode_o, .submux_channel_select_o,
		.gain_select_o, .irq_o);
	acq_adc_model u_adc (.clk_i, .rst_i, .convert_i(convert_o), .data_o(adc_data_i));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wrap_up;
		if (errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
		if (n >= 50) begin
			errors++;
			wrap_up();
		end
	endtask : wb
	// Polling reads clear the sticky flag, which is what the host does anyway
	task automatic wait_eoc;
		int n;
		n = 0;
		do begin
			wb(0, ADR_STATUS, 32'h0000_0000);
			n++;
		end while (q[ST_EOC] !== 1'b1 && n < 2000);
		chk("eoc", q[ST_EOC], 1'b1);
		if (n >= 2000) wrap_up();
	endtask : wait_eoc
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		wb(0, ADR_CHGAIN, 32'h0000_0000);
		chk("chgain reset", q, 32'h0000_0000);
		wb(1, ADR_CHGAIN, 32'h0000_005A);
		wb(0, ADR_CHGAIN, 32'h0000_0000);
		chk("chgain", q, 32'h0000_005A);
		chk("submux", submux_channel_select_o, 4'hA);
		chk("gain", gain_select_o, 3'h5);
		wb(0, 8'hFC, 32'h0000_0000);
		chk("unmapped", q, 32'h0000_0000);
	endtask : t_regs
	task automatic t_soft_irq;
		int n;
		wb(1, ADR_MASK, 32'h0000_0001);
		wb(1, ADR_CONTROL, 32'h0000_001C);
		// Mode pin follows the control register one edge later
		@(posedge clk_i);
		chk("diff", diff_mode_o, 1'b1);
		for (n = 0; n < 3000 && irq_o !== 1'b1; n++) @(posedge clk_i);
		chk("irq set", irq_o, 1'b1);
		if (n >= 3000) wrap_up();
		wb(0, ADR_STATUS, 32'h0000_0000);
		chk("status", q[ST_EOC], 1'b1);
		repeat (3) @(posedge clk_i);
		chk("irq clr", irq_o, 1'b0);
		wb(0, ADR_DATA, 32'h0000_0000);
		chk("soft data", q[15:0], 16'hA111);
	endtask : t_soft_irq
	task automatic t_ext_timer;
		wb(1, ADR_CONTROL, 32'h0000_0022);
		ext_trig_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		ext_trig_i <= 1'b0;
		wait_eoc();
		wb(0, ADR_DATA, 32'h0000_0000);
		chk("ext data", q[15:0], 16'hA222);
		wb(1, ADR_TIMER, 32'h0000_0001);
		wb(1, ADR_CONTROL, 32'h0000_0021);
		wait_eoc();
		wb(0, ADR_DATA, 32'h0000_0000);
		chk("timer data", q[15:0], 16'hA333);
		wb(1, ADR_CONTROL, 32'h0000_0080);
		wb(0, ADR_LEVEL, 32'h0000_0000);
		chk("level clr", q, 32'h0000_0000);
	endtask : t_ext_timer
	task automatic t_plist;
		wb(1, ADR_PLIST, 32'h0000_0073);
		wb(0, ADR_PLCOUNT, 32'h0000_0000);
		chk("plcount", q, 32'h0000_0001);
		wb(1, ADR_CONTROL, 32'h0000_0010);
		wait_eoc();
		chk("mux chan", mux_chan_o, 4'h3);
		wb(0, ADR_DATA, 32'h0000_0000);
		chk("list data", q[15:0], 16'h7444);
	endtask : t_plist
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_soft_irq();
		t_ext_timer();
		t_plist();
		wrap_up();
	end
endmodule : testbench
